/* dv/rei_cpu_model.sv */
// Instruction sequencer model facing the exception unit
`timescale 1ns/1ps
`default_nettype none
module rei_cpu_model
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic cpu_halt,
	input wire logic exc_start,
	input wire logic exc_set_mask,
	input wire logic flags_req,
	input wire logic mask_clr,
	output logic instr_boundary,
	output logic flags_instr_done,
	output logic global_mask_flag
);
	logic [1:0] cnt;
	// ---------------------------------------------------------------
	// Instruction boundaries, one every four clocks while running
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt <= 2'h0;
			instr_boundary <= 1'h0;
			flags_instr_done <= 1'h0;
		end
		else
		begin
			cnt <= cpu_halt ? 2'h0 : cnt + 2'h1;
			instr_boundary <= !cpu_halt && cnt == 2'h3;
			flags_instr_done <= flags_req;
		end
	end
	// ---------------------------------------------------------------
	// Mask flag, cleared only when software is told to
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			global_mask_flag <= 1'h1;
		else if (exc_start && exc_set_mask)
			global_mask_flag <= 1'h1;
		else if (mask_clr)
			global_mask_flag <= 1'h0;
	end
endmodule
`default_nettype wire

/* dv/rei_unit_tb.sv */
// Self-checking testbench of the exception unit
`timescale 1ns/1ps
`default_nettype none
module rei_unit_tb;
	logic sys_clk = 1'h0;
	logic arst_n = 1'h0;
	logic chip_clear_pin = 1'h1;
	logic nmi_pin = 1'h1;
	logic wdt_overflow = 1'h0;
	logic flags_req = 1'h0;
	logic mask_clr = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] ext_request_lines = 8'hff;
	logic [7:0] key_sense_inputs = 8'hff;
	logic [25:0] periph_req = 26'h0;
	logic instr_boundary, flags_instr_done, global_mask_flag, cpu_halt;
	logic exc_start, exc_push_context, exc_set_mask, pready, pslverr, er;
	logic [5:0] exc_num;
	logic [15:0] exc_vector_addr;
	logic [31:0] prdata, rd;
	logic [23:0] q[$];
	logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
	logic [31:0] rv[5] = '{32'h0, 32'h0, 32'h0, 32'hbf, 32'h3ffffff};
	int n_mismatch = 0;
	int checked = 0;
	int seed = 86096;
	int n, idx;

	always #50 sys_clk = ~sys_clk;

	rei_unit i_dut (.sys_clk, .arst_n, .chip_clear_pin, .nmi_pin,
		.ext_request_lines, .key_sense_inputs, .periph_req, .wdt_overflow,
		.global_mask_flag, .instr_boundary, .flags_instr_done, .cpu_halt,
		.exc_start, .exc_num, .exc_vector_addr, .exc_push_context,
		.exc_set_mask, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr);
	rei_cpu_model i_cpu (.sys_clk, .arst_n, .cpu_halt, .exc_start,
		.exc_set_mask, .flags_req, .mask_clr, .instr_boundary,
		.flags_instr_done, .global_mask_flag);

	// ---------------------------------------------------------------
	// Checking and closing
	// ---------------------------------------------------------------
	task check(input string nm, input logic [31:0] got, exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task wrap_up;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Any exception nobody noted is a fault
	always @(posedge sys_clk)
	begin
		if (exc_start === 1'h1)
		begin
			if (q.size() == 0)
				check("unexpected exception", 32'h0, 32'h1);
			else
				check("exception", {exc_push_context, exc_set_mask, exc_num,
					exc_vector_addr}, q.pop_front());
		end
	end

	initial
	begin
		#(100 * 30000);
		n_mismatch++;
		wrap_up;
	end

	// ---------------------------------------------------------------
	// Drivers
	// ---------------------------------------------------------------
	task tick(input int k);
		repeat (k) @(posedge sys_clk);
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		@(posedge sys_clk);
		while (pready !== 1'h1) @(posedge sys_clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task wait_q;
		int k;
		for (k = 0; k < 300 && q.size() != 0; k++) @(posedge sys_clk);
		check("missing exception", q.size(), 32'h0);
		q.delete();
	endtask

	task note_exc(input logic [5:0] num, input logic push);
		q.push_back({push, 1'h1, num, 9'h000, num, 1'h0});
	endtask

	task expect_exc(input logic [5:0] num, input logic push);
		note_exc(num, push);
		wait_q;
	endtask

	task unmask;
		@(posedge sys_clk);
		mask_clr <= 1'h1;
		@(posedge sys_clk);
		mask_clr <= 1'h0;
	endtask

	task pulse_wdt;
		@(posedge sys_clk);
		wdt_overflow <= 1'h1;
		@(posedge sys_clk);
		wdt_overflow <= 1'h0;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial
	begin
		q.push_back(24'h400000);
		tick(16); // Power-on hold kept short
		arst_n <= 1'h1;
		wait_q;
		foreach (ra[i])
		begin
			apb(1'h0, ra[i], 32'h0);
			check("reset value", rd, rv[i]);
		end
		apb(1'h1, 8'h10, 32'h1);
		check("read-only write", er, 1'h1);
		apb(1'h0, 8'h18, 32'h0);
		check("unmapped", er, 1'h1);
		// Held off by flags instructions, yet taken under mask
		flags_req <= 1'h1;
		nmi_pin <= 1'h0;
		tick(20);
		flags_req <= 1'h0;
		expect_exc(6'h03, 1'h1);
		nmi_pin <= 1'h1;
		tick(20);
		apb(1'h1, 8'h00, 32'h1);
		nmi_pin <= 1'h0;
		tick(20);
		nmi_pin <= 1'h1;
		expect_exc(6'h03, 1'h1);
		apb(1'h1, 8'h00, 32'h0);
		apb(1'h1, 8'h08, 32'hff);
		ext_request_lines <= 8'hdb;
		tick(20);
		unmask;
		expect_exc(6'h06, 1'h1);
		ext_request_lines <= 8'hdf;
		unmask;
		expect_exc(6'h09, 1'h1);
		ext_request_lines <= 8'hff;
		apb(1'h1, 8'h04, 32'h1);
		ext_request_lines <= 8'hfe;
		tick(1);
		ext_request_lines <= 8'hff;
		unmask;
		expect_exc(6'h04, 1'h1);
		key_sense_inputs <= 8'hf7;
		unmask;
		tick(20);
		apb(1'h1, 8'h0c, 32'hb7);
		expect_exc(6'h0a, 1'h1);
		key_sense_inputs <= 8'hff;
		for (int k = 0; k < 5; k++)
		begin
			idx = k == 0 ? 25 : $unsigned($random(seed)) % 26;
			periph_req <= 26'h1 << idx;
			unmask;
			expect_exc(6'(12 + idx), 1'h1);
		end
		periph_req <= 26'h0;
		// Noted first: an unmaskable request may be taken before unmask
		for (int m = 0; m < 2; m++)
		begin
			apb(1'h1, 8'h00, 32'(m << 1));
			note_exc(m ? 6'h03 : 6'h24, 1'h1);
			pulse_wdt;
			unmask;
			wait_q;
		end
		apb(1'h0, 8'h10, 32'h0);
		check("status", rd, 32'h00010c00);
		apb(1'h1, 8'h00, 32'h4);
		q.push_back(24'h400000);
		pulse_wdt;
		n = 0;
		repeat (600)
		begin
			tick(1);
			n += cpu_halt === 1'h1;
		end
		// One clock of state latency tolerated
		check("watchdog pulse", n == 518 || n == 519, 1'h1);
		wait_q;
		apb(1'h0, 8'h00, 32'h0);
		check("ctrl after watchdog", rd, 32'h0);
		apb(1'h1, 8'h00, 32'h1);
		chip_clear_pin <= 1'h0;
		tick(10);
		check("halt", cpu_halt, 1'h1);
		q.push_back(24'h400000);
		chip_clear_pin <= 1'h1;
		wait_q;
		apb(1'h0, 8'h00, 32'h0);
		check("ctrl after clear", rd, 32'h0);
		wrap_up;
	end
endmodule
`default_nettype wire

/* hdl/rei_unit.sv */
// Reset and interrupt exception unit with APB register slave
//
// Contract
// - Reset outranks every interrupt; only reset and interrupts exist.
// - Reset exception starts, clocked, when chip clear pin rises.
// - Interrupts start only at instruction or exception-sequence end.
// - No interrupt detection right after any of four flags instructions.
// - Clear pin low or watchdog reset halts all and initialises.
// - Watchdog reset exception starts when its pulse ends.
// - Watchdog reset pulse lasts exactly 518 clocks.
// - Reset sequence sets the global mask flag.
// - Reset loads program counter from vector word at zero.
// - All interrupts, even unmaskable, blocked until first instruction ends.
// - Nine external sources on 23 pins plus 26 peripheral sources; the code has 17 pins (NMI, eight request lines, eight key inputs).
// - Simultaneous requests served in fixed priority order.
// - Unmaskable always taken first; global mask refuses all others.
// - Each request line is edge or level sensed, chosen per line.
// - Unmaskable request is edge sensed only.
// - Every source has its own vector.
// - Eight key inputs, each maskable, merge onto request line six.
// - Watchdog raises unmaskable or ordinary overflow interrupt.
// - Sources numbered 3 to 37, vector at twice the number.
// - Unmaskable edge select 0 falling, 1 rising.
// - Sense select 0 low level, 1 falling edge.
// - Line enable bit 1 enables; all reset to 0.
// - Key mask 0 enables; all reset to 1 except input six.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rei_unit
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic chip_clear_pin,
	input wire logic nmi_pin,
	input wire logic [7:0] ext_request_lines,
	input wire logic [7:0] key_sense_inputs,
	input wire logic [25:0] periph_req,
	input wire logic wdt_overflow,
	input wire logic global_mask_flag,
	input wire logic instr_boundary,
	input wire logic flags_instr_done,
	output logic cpu_halt,
	output logic exc_start,
	output logic [5:0] exc_num,
	output logic [15:0] exc_vector_addr,
	output logic exc_push_context,
	output logic exc_set_mask,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [5:0] first_src(input logic [34:0] v);
		logic [5:0] r;
		r = rei_pkg::EXC_NONE;
		for (int i = rei_pkg::NUM_SRC - 1; i >= 0; i--)
			if (v[i])
				r = i[5:0];
		return r;
	endfunction

	function automatic logic [15:0] vec_of(input logic [5:0] num);
		return {9'h000, num, 1'b0};
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return a == rei_pkg::REG_CTRL || a == rei_pkg::REG_SENSE ||
			a == rei_pkg::REG_ENABLE || a == rei_pkg::REG_KEYMASK ||
			a == rei_pkg::REG_STATUS || a == rei_pkg::REG_PERIPH_EN;
	endfunction

	rei_pkg::rei_state_e state;
	rei_pkg::rei_state_e next_state;
	logic [2:0] ctrl;
	logic [7:0] sense_sel;
	logic [7:0] line_en;
	logic [7:0] key_mask;
	logic [25:0] periph_en;
	logic nmi_prev;
	logic [7:0] irq_prev;
	logic nmi_pend;
	logic [7:0] edge_pend;
	logic wovf_pend;
	logic post_block;
	logic [5:0] last_num;
	logic wdt_active;
	logic wdt_trig;
	logic hold;
	logic [7:0] irq_in;
	logic [7:0] irq_req;
	logic [7:0] irq_fall;
	logic nmi_edge;
	logic [25:0] per_req;
	logic [34:0] src_vec;
	logic [5:0] win_idx;
	logic accept;
	logic go_reset;
	logic apb_wr;
	logic [1:0] wdt_mode;

	// ---------------------------------------------------------------
	// Reset sequencing
	// ---------------------------------------------------------------
	assign wdt_mode = ctrl[rei_pkg::CTRL_WDT_LSB +: 2];
	assign wdt_trig = wdt_overflow && state == rei_pkg::ST_RUN &&
		wdt_mode == rei_pkg::WDT_DO_RESET;

	rei_wdt_pulse u_wdt_pulse
	(
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.trigger(wdt_trig),
		.active(wdt_active)
	);

	// Reset wins over any interrupt by taking the state away from run
	always_comb
	begin
		next_state = state;
		if (!chip_clear_pin || wdt_active)
			next_state = rei_pkg::ST_HOLD;
		else
			unique case (state)
				rei_pkg::ST_HOLD:
					next_state = rei_pkg::ST_RESET_EXC;
				rei_pkg::ST_RESET_EXC:
					next_state = rei_pkg::ST_RUN;
				rei_pkg::ST_RUN:
					next_state = rei_pkg::ST_RUN;
				default:
					next_state = rei_pkg::ST_HOLD;
			endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			state <= rei_pkg::ST_HOLD;
		else
			state <= next_state;
	end

	assign hold = (state == rei_pkg::ST_HOLD);
	assign go_reset = (state == rei_pkg::ST_RESET_EXC);
	assign cpu_halt = hold;

	// ---------------------------------------------------------------
	// Registers, returned to their reset values while the chip is held in reset
	// ---------------------------------------------------------------
	assign apb_wr = psel && penable && pwrite;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ctrl <= rei_pkg::CTRL_RESET;
			sense_sel <= rei_pkg::SENSE_RESET;
			line_en <= rei_pkg::ENABLE_RESET;
			key_mask <= rei_pkg::KEYMASK_RESET;
			periph_en <= rei_pkg::PERIPH_EN_RESET;
		end
		else if (hold)
		begin
			ctrl <= rei_pkg::CTRL_RESET;
			sense_sel <= rei_pkg::SENSE_RESET;
			line_en <= rei_pkg::ENABLE_RESET;
			key_mask <= rei_pkg::KEYMASK_RESET;
			periph_en <= rei_pkg::PERIPH_EN_RESET;
		end
		else if (apb_wr)
		begin
			if (paddr == rei_pkg::REG_CTRL)
				ctrl <= pwdata[2:0];
			if (paddr == rei_pkg::REG_SENSE)
				sense_sel <= pwdata[7:0];
			if (paddr == rei_pkg::REG_ENABLE)
				line_en <= pwdata[7:0];
			if (paddr == rei_pkg::REG_KEYMASK)
				key_mask <= pwdata[7:0];
			if (paddr == rei_pkg::REG_PERIPH_EN)
				periph_en <= pwdata[25:0];
		end
	end

	// Read data captured in setup, so the access phase needs no wait
	assign pready = 1'b1;
	assign pslverr = psel && penable &&
		(!mapped(paddr) || (pwrite && paddr == rei_pkg::REG_STATUS));

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			prdata <= 32'h00000000;
		else if (psel && !penable && !pwrite)
		begin
			prdata <= 32'h00000000;
			unique case (paddr)
				rei_pkg::REG_CTRL:
					prdata <= {29'h00000000, ctrl};
				rei_pkg::REG_SENSE:
					prdata <= {24'h000000, sense_sel};
				rei_pkg::REG_ENABLE:
					prdata <= {24'h000000, line_en};
				rei_pkg::REG_KEYMASK:
					prdata <= {24'h000000, key_mask};
				rei_pkg::REG_STATUS:
					prdata <= {15'h0000, global_mask_flag, last_num,
						wovf_pend, nmi_pend, edge_pend};
				rei_pkg::REG_PERIPH_EN:
					prdata <= {6'h00, periph_en};
				default:
					prdata <= 32'h00000000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Request detection (pins are active low)
	// ---------------------------------------------------------------
	always_comb
	begin
		irq_in = ext_request_lines;
		// Any unmasked key input held low pulls line six low
		irq_in[rei_pkg::KEY_IRQ_LINE] = ext_request_lines[rei_pkg::KEY_IRQ_LINE]
			& (&(key_sense_inputs | key_mask));
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			nmi_prev <= 1'b1;
			irq_prev <= 8'hff;
		end
		else
		begin
			nmi_prev <= nmi_pin;
			irq_prev <= irq_in;
		end
	end

	assign nmi_edge = ctrl[rei_pkg::CTRL_EDGE_BIT] ?
		(!nmi_prev && nmi_pin) : (nmi_prev && !nmi_pin);
	assign irq_fall = irq_prev & ~irq_in & sense_sel & line_en;

	// Set wins over the clear of acceptance in the same cycle
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			nmi_pend <= 1'b0;
		else if (hold)
			nmi_pend <= 1'b0;
		else if (nmi_edge ||
			(wdt_overflow && wdt_mode == rei_pkg::WDT_DO_NMI))
			nmi_pend <= 1'b1;
		else if (accept && win_idx == 6'h00)
			nmi_pend <= 1'b0;
	end

	// Edge requests outlive a later disable; the clear recipe drops them
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			edge_pend <= 8'h00;
		else if (hold)
			edge_pend <= 8'h00;
		else
			for (int i = 0; i < rei_pkg::NUM_IRQ; i++)
			begin
				if (irq_fall[i])
					edge_pend[i] <= 1'b1;
				else if (accept && win_idx == 6'(i + 1))
					edge_pend[i] <= 1'b0;
				else if (global_mask_flag && !sense_sel[i] && !line_en[i])
					edge_pend[i] <= 1'b0;
			end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			wovf_pend <= 1'b0;
		else if (hold)
			wovf_pend <= 1'b0;
		else if (wdt_overflow && wdt_mode == rei_pkg::WDT_DO_INT)
			wovf_pend <= 1'b1;
		else if (accept &&
			win_idx == 6'(1 + rei_pkg::NUM_IRQ + rei_pkg::PERIPH_WDT_IDX))
			wovf_pend <= 1'b0;
	end

	always_comb
	begin
		for (int i = 0; i < rei_pkg::NUM_IRQ; i++)
			irq_req[i] = sense_sel[i] ? edge_pend[i]
				: (line_en[i] && !irq_in[i]);
		per_req = periph_req & periph_en;
		per_req[rei_pkg::PERIPH_WDT_IDX] = per_req[rei_pkg::PERIPH_WDT_IDX]
			| wovf_pend;
	end

	// ---------------------------------------------------------------
	// Priority and acceptance
	// ---------------------------------------------------------------
	// Mask applies to all but the unmaskable source in bit 0
	assign src_vec = {{per_req, irq_req} & {34{!global_mask_flag}},
		nmi_pend};
	assign win_idx = first_src(src_vec);

	// Boundary is the end of an instruction or of an exception sequence
	assign accept = state == rei_pkg::ST_RUN && instr_boundary
		&& !flags_instr_done
		&& !post_block
		&& win_idx != rei_pkg::EXC_NONE;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			post_block <= 1'b1;
		else if (hold || go_reset)
			post_block <= 1'b1;
		else if (instr_boundary)
			post_block <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			exc_start <= 1'b0;
			exc_num <= rei_pkg::EXC_RESET;
			exc_vector_addr <= rei_pkg::VEC_RESET;
			exc_push_context <= 1'b0;
			exc_set_mask <= 1'b0;
		end
		else if (go_reset)
		begin
			exc_start <= 1'b1;
			exc_num <= rei_pkg::EXC_RESET;
			exc_vector_addr <= rei_pkg::VEC_RESET;
			exc_push_context <= 1'b0;
			exc_set_mask <= 1'b1;
		end
		else if (accept)
		begin
			exc_start <= 1'b1;
			exc_num <= win_idx + rei_pkg::EXC_NMI;
			exc_vector_addr <= vec_of(win_idx + rei_pkg::EXC_NMI);
			exc_push_context <= 1'b1;
			exc_set_mask <= 1'b1;
		end
		else
		begin
			exc_start <= 1'b0;
			exc_push_context <= 1'b0;
			exc_set_mask <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			last_num <= rei_pkg::EXC_RESET;
		else if (exc_start)
			last_num <= exc_num;
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	sequence s_reset_vector;
		exc_start && exc_num == rei_pkg::EXC_RESET &&
			exc_vector_addr == rei_pkg::VEC_RESET && exc_set_mask;
	endsequence

	property p_reset_vec;
		@(posedge sys_clk) disable iff (!arst_n)
		go_reset |=> s_reset_vector and !exc_push_context;
	endproperty
	a_reset_vec: assert property (p_reset_vec)
		else $error("reset exception did not fetch vector zero");

	property p_clear_start;
		@(posedge sys_clk) disable iff (!arst_n)
		arst_n && hold && chip_clear_pin && !wdt_active
			|-> ##2 s_reset_vector;
	endproperty
	a_clear_start: assert property (p_clear_start)
		else $error("reset exception late after clear release");

	property p_hold_halt;
		@(posedge sys_clk) disable iff (!arst_n)
		!chip_clear_pin |=> cpu_halt && !exc_start;
	endproperty
	a_hold_halt: assert property (p_hold_halt)
		else $error("clear pin low did not halt processing");

	property p_wdt_end;
		@(posedge sys_clk) disable iff (!arst_n)
		$fell(wdt_active) && chip_clear_pin |-> ##[1:2] s_reset_vector;
	endproperty
	a_wdt_end: assert property (p_wdt_end)
		else $error("no reset exception at watchdog pulse end");

	property p_flags_block;
		@(posedge sys_clk) disable iff (!arst_n)
		state == rei_pkg::ST_RUN && instr_boundary && flags_instr_done
			|=> !exc_start;
	endproperty
	a_flags_block: assert property (p_flags_block)
		else $error("interrupt taken after flags instruction");

	property p_post_reset;
		@(posedge sys_clk) disable iff (!arst_n)
		post_block && instr_boundary && !go_reset |=> !exc_start;
	endproperty
	a_post_reset: assert property (p_post_reset)
		else $error("interrupt taken at first boundary after reset");

	property p_first_boundary;
		@(posedge sys_clk) disable iff (!arst_n)
		state == rei_pkg::ST_RUN && post_block && instr_boundary
			|=> !exc_start ##1 !post_block;
	endproperty
	a_first_boundary: assert property (p_first_boundary)
		else $error("interrupt taken before first instruction");

	property p_only_boundary;
		@(posedge sys_clk) disable iff (!arst_n)
		exc_start && exc_num != rei_pkg::EXC_RESET |->
			$past(instr_boundary) && $past(state) == rei_pkg::ST_RUN;
	endproperty
	a_only_boundary: assert property (p_only_boundary)
		else $error("interrupt started away from a boundary");

	property p_mask_refuse;
		@(posedge sys_clk) disable iff (!arst_n)
		accept && global_mask_flag |=> exc_num == rei_pkg::EXC_NMI;
	endproperty
	a_mask_refuse: assert property (p_mask_refuse)
		else $error("masked interrupt accepted");

	property p_nmi_first;
		@(posedge sys_clk) disable iff (!arst_n)
		accept && nmi_pend |=> exc_num == rei_pkg::EXC_NMI &&
			exc_push_context ##1 !nmi_pend || $past(nmi_edge);
	endproperty
	a_nmi_first: assert property (p_nmi_first)
		else $error("unmaskable request not served first");

	property p_vector_map;
		@(posedge sys_clk) disable iff (!arst_n)
		exc_start |-> exc_vector_addr == vec_of(exc_num) &&
			exc_vector_addr <= rei_pkg::VEC_LAST;
	endproperty
	a_vector_map: assert property (p_vector_map)
		else $error("vector address not twice the number");
endmodule
`default_nettype wire

/* hdl/rei_wdt_pulse.sv */
// Fixed-length internal reset pulse started by a watchdog overflow
`timescale 1ns/1ps
`default_nettype none
module rei_wdt_pulse
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic trigger,
	output logic active
);
	logic [9:0] remain;
	logic [9:0] seen;

	// Not cleared by the reset it produces, or it would cut itself short
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			remain <= 10'h000;
		else if (remain != 10'h000)
			remain <= remain - 10'h001;
		else if (trigger)
			remain <= rei_pkg::WDT_PULSE_CYCLES;
	end

	assign active = (remain != 10'h000);

	// Helper: length of the pulse now running
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			seen <= 10'h000;
		else if (active)
			seen <= seen + 10'h001;
		else
			seen <= 10'h000;
	end

	property p_pulse_len;
		@(posedge sys_clk) disable iff (!arst_n)
		$fell(active) |-> seen == rei_pkg::WDT_PULSE_CYCLES;
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("watchdog reset pulse length wrong");
endmodule
`default_nettype wire

/* pkg/rei_pkg.sv */
// Shared constants of the reset and interrupt exception unit
package rei_pkg;
	// ---------------------------------------------------------------
	// Register map (APB byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_SENSE = 8'h04;
	localparam logic [7:0] REG_ENABLE = 8'h08;
	localparam logic [7:0] REG_KEYMASK = 8'h0c;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_PERIPH_EN = 8'h14;
	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int CTRL_EDGE_BIT = 0;
	localparam int CTRL_WDT_LSB = 1;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [7:0] SENSE_RESET = 8'h00;
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] KEYMASK_RESET = 8'hbf;
	localparam logic [25:0] PERIPH_EN_RESET = 26'h3ffffff;
	localparam int STAT_NMI_BIT = 8;
	localparam int STAT_WOVF_BIT = 9;
	localparam int STAT_NUM_LSB = 10;
	localparam int STAT_MASK_BIT = 16;
	// ---------------------------------------------------------------
	// Watchdog overflow actions
	// ---------------------------------------------------------------
	localparam logic [1:0] WDT_DO_INT = 2'h0;
	localparam logic [1:0] WDT_DO_NMI = 2'h1;
	localparam logic [1:0] WDT_DO_RESET = 2'h2;
	// ---------------------------------------------------------------
	// Sources and exception numbers
	// ---------------------------------------------------------------
	localparam int NUM_IRQ = 8;
	localparam int NUM_PERIPH = 26;
	localparam int NUM_SRC = 35;
	localparam int KEY_IRQ_LINE = 6;
	localparam int PERIPH_WDT_IDX = 24;
	localparam logic [5:0] EXC_RESET = 6'h00;
	localparam logic [5:0] EXC_NMI = 6'h03;
	localparam logic [5:0] EXC_NONE = 6'h3f;
	localparam logic [15:0] VEC_RESET = 16'h0000;
	localparam logic [15:0] VEC_LAST = 16'h004a;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam logic [9:0] WDT_PULSE_CYCLES = 10'h206;
	// ---------------------------------------------------------------
	// Sequencer states, Gray along hold, exception, run
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_HOLD = 2'h0,
		ST_RESET_EXC = 2'h1,
		ST_RUN = 2'h3
	} rei_state_e;
endpackage
